/* File: src/swi_slave.sv */
// Single-wire slave: presence, interrupt signalling, bit slots, FIFO
`include "swi_consts.svh"
`default_nettype none
module swi_slave #(
    parameter bit LATE_REVISION = 1'b1,
    parameter int unsigned INT_LOW_CYC = `SWI_INT_LOW_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus pin, open drain; enable low while pulling
    input wire logic lineIn,
    output logic lineOut,
    output logic lineOe_n,
    // Alarm side
    input wire logic alarm,
    input wire logic ackAlarm,
    input wire logic addressedSelf,
    input wire logic addressedOther,
    output logic intPending,
    // Transmit bytes for read slots
    input wire logic txValid,
    output logic txReady,
    input wire logic [7:0] txData,
    // Received bytes from write slots
    output logic rxValid,
    output logic [7:0] rxData
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_RESET_LOW, ST_STRETCH, ST_PRES_WAIT, ST_PRES_LOW,
        ST_SPONT, ST_SLOT
    } state_t;

    state_t state_reg;
    logic [`SWI_CNT_W-1:0] cnt_reg;
    logic [`SWI_CNT_W-1:0] lowCnt_reg;
    logic lineDly_reg;
    logic fall;
    logic rise;
    logic armed_reg;
    logic traffic_reg;
    logic pending_reg;
    logic signaled_reg;
    logic powerOn_reg;
    logic stretchNext_reg;
    logic pull_reg;
    logic readBit_reg;
    logic [2:0] bitIdx_reg;
    logic [7:0] rxShift_reg;
    swi_pkg::swi_wave_t wave_reg;
    swi_fifo_if fifoBus();

    assign fall = lineDly_reg && !lineIn;
    assign rise = !lineDly_reg && lineIn;
    assign lineOut = 1'b0;
    assign lineOe_n = !pull_reg;
    assign intPending = pending_reg;

    swi_fifo #(.WIDTH(`SWI_FIFO_W), .DEPTH(`SWI_FIFO_D)) txFifo (
        .clk(clk),
        .rst(rst),
        .inValid(fifoBus.inValid),
        .inReady(fifoBus.inReady),
        .inData(fifoBus.inData),
        .outValid(fifoBus.outValid),
        .outReady(fifoBus.outReady),
        .outData(fifoBus.outData)
    );
    assign fifoBus.inValid = txValid;
    assign fifoBus.inData = txData;
    assign txReady = fifoBus.inReady;

    // Edge detector on the pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lineDly_reg <= 1'b1;
        end else begin
            lineDly_reg <= lineIn;
        end
    end

    // Length of the current low phase on the line
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lowCnt_reg <= '0;
        end else if (lineIn) begin
            lowCnt_reg <= '0;
        end else if (lowCnt_reg != '1) begin
            lowCnt_reg <= lowCnt_reg + 1'b1;
        end
    end

    // Alarm pending until acknowledged; a new alarm wins over the ack
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pending_reg <= 1'b0;
        end else if (alarm) begin
            pending_reg <= 1'b1;
        end else if (ackAlarm) begin
            pending_reg <= 1'b0;
        end
    end

    // Which waveform repeated signalling uses
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wave_reg <= swi_pkg::SWI_WAVE_DELAYED;
        end else if (!LATE_REVISION || addressedOther) begin
            wave_reg <= swi_pkg::SWI_WAVE_DELAYED;
        end else if (addressedSelf) begin
            wave_reg <= swi_pkg::SWI_WAVE_AFTER_PRESENCE;
        end
    end

    // Power-on flag: set by reset, cleared once the first presence pull starts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            powerOn_reg <= 1'b1;
        end else if (state_reg == ST_PRES_LOW) begin
            powerOn_reg <= 1'b0;
        end
    end

    // Main sequencer, intervals counted from entry into each state; the stretch and the slot's reset detection also from the line fall
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            pull_reg <= 1'b0;
            armed_reg <= 1'b0;
            traffic_reg <= 1'b0;
            signaled_reg <= 1'b0;
            stretchNext_reg <= 1'b0;
            readBit_reg <= 1'b1;
            bitIdx_reg <= '0;
            rxShift_reg <= '0;
            rxValid <= 1'b0;
            rxData <= '0;
            fifoBus.outReady <= 1'b0;
        end else begin
            rxValid <= 1'b0;
            fifoBus.outReady <= 1'b0;
            if (alarm) begin
                signaled_reg <= 1'b0;
            end
            // Our own pull makes no disarming edge
            if (fall && !pull_reg) begin
                armed_reg <= 1'b0;
            end
            case (state_reg)
                ST_IDLE: begin
                    pull_reg <= 1'b0;
                    cnt_reg <= '0;
                    if (powerOn_reg && lineIn
                            && lowCnt_reg == '0 && cnt_reg == '0) begin
                        state_reg <= ST_PRES_WAIT;
                        stretchNext_reg <= pending_reg;
                    end else if (pending_reg && !signaled_reg && armed_reg
                            && lineIn && !fall) begin
                        state_reg <= ST_SPONT;
                        pull_reg <= 1'b1;
                    end else if (fall) begin
                        state_reg <= ST_SLOT;
                        cnt_reg <= '0;
                        readBit_reg <= fifoBus.outValid
                            ? fifoBus.outData[bitIdx_reg] : 1'b1;
                        pull_reg <= fifoBus.outValid
                            && !fifoBus.outData[bitIdx_reg];
                    end
                end
                ST_SLOT: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == `SWI_CNT_W'(`SWI_READ_VALID_CYC - 1)) begin
                        pull_reg <= 1'b0;
                    end
                    if (cnt_reg == `SWI_CNT_W'(`SWI_SAMPLE_CYC)) begin
                        traffic_reg <= 1'b1;
                        rxShift_reg <= {lineIn, rxShift_reg[7:1]};
                        bitIdx_reg <= bitIdx_reg + 1'b1;
                        if (bitIdx_reg == 3'h7) begin
                            rxValid <= 1'b1;
                            rxData <= {lineIn, rxShift_reg[7:1]};
                            fifoBus.outReady <= fifoBus.outValid;
                        end
                    end
                    if (lowCnt_reg == `SWI_CNT_W'(`SWI_RST_DETECT_CYC)) begin
                        state_reg <= ST_RESET_LOW;
                        pull_reg <= 1'b0;
                    end else if (cnt_reg > `SWI_CNT_W'(`SWI_SAMPLE_CYC)
                            && lineIn) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_RESET_LOW: begin
                    bitIdx_reg <= '0;
                    if (traffic_reg) begin
                        armed_reg <= 1'b1;
                        traffic_reg <= 1'b0;
                    end
                    // A rise ends this reset, also after our own stretch
                    if (rise) begin
                        state_reg <= ST_PRES_WAIT;
                        cnt_reg <= '0;
                    end else if (pending_reg && !signaled_reg) begin
                        pull_reg <= 1'b1;
                        cnt_reg <= '0;
                        signaled_reg <= 1'b1;
                        state_reg <= ST_STRETCH;
                    end else if (pending_reg && (stretchNext_reg
                            || wave_reg == swi_pkg::SWI_WAVE_DELAYED)) begin
                        state_reg <= ST_STRETCH;
                        pull_reg <= 1'b1;
                        cnt_reg <= '0;
                    end
                    stretchNext_reg <= 1'b0;
                end
                ST_STRETCH: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (lowCnt_reg >= `SWI_CNT_W'(`SWI_INT_TOTAL_CYC)
                            && cnt_reg >= `SWI_CNT_W'(INT_LOW_CYC
                            - `SWI_INT_TOTAL_CYC)) begin
                        pull_reg <= 1'b0;
                        state_reg <= ST_RESET_LOW;
                        signaled_reg <= 1'b1;
                    end
                end
                ST_PRES_WAIT: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == `SWI_CNT_W'(`SWI_PRES_WAIT_CYC - 1)) begin
                        pull_reg <= 1'b1;
                        cnt_reg <= '0;
                        state_reg <= ST_PRES_LOW;
                    end
                end
                ST_PRES_LOW: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == `SWI_CNT_W'(`SWI_PRES_LOW_CYC - 1)) begin
                        pull_reg <= 1'b0;
                        cnt_reg <= '0;
                        if (pending_reg && LATE_REVISION
                                && wave_reg
                                == swi_pkg::SWI_WAVE_AFTER_PRESENCE) begin
                            state_reg <= ST_SPONT;
                            pull_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_SPONT: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == `SWI_CNT_W'(INT_LOW_CYC - 1)) begin
                        pull_reg <= 1'b0;
                        signaled_reg <= 1'b1;
                        cnt_reg <= '0;
                        state_reg <= ST_PRES_WAIT;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    pull_reg <= 1'b0;
                end
            endcase
        end
    end
endmodule : swi_slave
`default_nettype wire

/* File: src/swi_consts.svh */
// Timing constants and widths for the single-wire interrupt signalling slave
`ifndef SWI_CONSTS_SVH
`define SWI_CONSTS_SVH
`define SWI_CLK_MHZ 20
`define SWI_CNT_W 17
// Times in microseconds as printed
`define SWI_RST_LOW_MIN_US 480
`define SWI_RST_LOW_MAX_US 960
`define SWI_RST_HIGH_MIN_US 480
`define SWI_PRES_WAIT_US 30
`define SWI_PRES_LOW_US 120
`define SWI_INT_LOW_US 1920
`define SWI_INT_TOTAL_MIN_US 960
`define SWI_READ_VALID_US 15
`define SWI_SAMPLE_US 30
`define SWI_POWER_ON_US 5
// Cycle counts derived from the clock rate
`define SWI_CYC(us) ((us) * `SWI_CLK_MHZ)
`define SWI_RST_DETECT_CYC `SWI_CYC(`SWI_RST_LOW_MIN_US)
`define SWI_PRES_WAIT_CYC `SWI_CYC(`SWI_PRES_WAIT_US)
`define SWI_PRES_LOW_CYC `SWI_CYC(`SWI_PRES_LOW_US)
`define SWI_INT_LOW_CYC `SWI_CYC(`SWI_INT_LOW_US)
`define SWI_INT_TOTAL_CYC `SWI_CYC(`SWI_INT_TOTAL_MIN_US)
`define SWI_READ_VALID_CYC `SWI_CYC(`SWI_READ_VALID_US)
`define SWI_SAMPLE_CYC `SWI_CYC(`SWI_SAMPLE_US)
`define SWI_POWER_ON_CYC `SWI_CYC(`SWI_POWER_ON_US)
`define SWI_FIFO_W 8
`define SWI_FIFO_D 8
`endif

/* File: src/swi_pkg.sv */
// Types for the single-wire interrupt signalling slave
`default_nettype none
package swi_pkg;
    typedef enum logic [1:0] {
        SWI_WAVE_DELAYED,
        SWI_WAVE_AFTER_PRESENCE
    } swi_wave_t;
endpackage : swi_pkg
`default_nettype wire

/* File: src/swi_fifo_if.sv */
// Handshake carrier between the slave and its byte FIFO
`default_nettype none
interface swi_fifo_if;
    logic inValid;
    logic inReady;
    logic [7:0] inData;
    logic outValid;
    logic outReady;
    logic [7:0] outData;
    modport fifo (input inValid, inData, outReady,
                  output inReady, outValid, outData);
    modport user (output inValid, inData, outReady,
                  input inReady, outValid, outData);
endinterface : swi_fifo_if
`default_nettype wire

/* File: src/swi_fifo.sv */
// Parameterised FIFO with valid and ready on both sides
`default_nettype none
module swi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Stream ports
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic doWr;
    logic doRd;

    assign inReady = (count_reg != (AW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData = mem[rdPtr_reg];
    assign doWr = inValid && inReady;
    assign doRd = outValid && outReady;

    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (doWr) begin
                wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
            end
            if (doRd) begin
                rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(doWr) - (AW+1)'(doRd);
        end
    end
endmodule : swi_fifo
`default_nettype wire

/* File: dv/swi_slave_sva.sv */
// Port assertions for the single-wire slave
`default_nettype none
module swi_slave_sva #(
    parameter int unsigned INT_LOW_CYC = 38400
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Wire
    input wire logic lineIn,
    input wire logic lineOe_n,
    // Alarm side
    input wire logic alarm,
    input wire logic ackAlarm,
    input wire logic intPending
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [16:0] lowCnt;
    logic [16:0] pullCnt;
    logic waitOn;
    logic [10:0] waitCnt;
    // Saturating lengths of the wire low and of our own pull
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lowCnt <= 17'h00000;
        end else begin
            lowCnt <= lineIn ? 17'h00000 : lowCnt + {16'h0000, ~&lowCnt};
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pullCnt <= 17'h00000;
        end else begin
            pullCnt <= lineOe_n ? 17'h00000 : pullCnt + {16'h0000, ~&pullCnt};
        end
    end
    // Cycles from the end of a reset-length low until our presence pull
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitOn <= 1'b0;
            waitCnt <= 11'h000;
        end else if (!lineOe_n) begin
            waitOn <= 1'b0;
            waitCnt <= 11'h000;
        end else if (lineIn && lowCnt >= 17'h02580) begin
            waitOn <= 1'b1;
            waitCnt <= 11'h001;
        end else if (waitOn) begin
            waitCnt <= waitCnt + {10'h000, ~&waitCnt};
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    pres_wait_a: assert property (
        waitOn |-> waitCnt <= 11'h4B0 && (lineOe_n || waitCnt >= 11'h12C))
        else $error("presence not started in time after reset");
    read_pull_a: assert property (
        $rose(lineOe_n) && pullCnt < 17'h003E8 |-> pullCnt == 17'h0012C)
        else $error("read pull length wrong");
    pres_len_a: assert property (
        $rose(lineOe_n) && pullCnt > 17'h003E8 && pullCnt < 17'h01388
        |-> pullCnt == 17'h00960)
        else $error("presence pull length wrong");
    own_pull_cap_a: assert property (
        $rose(lineOe_n) && pullCnt > 17'h01388 |-> pullCnt <= INT_LOW_CYC)
        else $error("interrupt pull too long");
    int_total_a: assert property (
        $rose(lineIn) && $past(lineOe_n) == 1'b0 && lowCnt >= 17'h02580
        |-> lowCnt inside {[17'h04B00:17'h17700]})
        else $error("stretched low outside limits");
    pend_hold_a: assert property (
        intPending && !ackAlarm |=> intPending)
        else $error("pending dropped without acknowledge");
    alarm_set_a: assert property (alarm |=> intPending)
        else $error("alarm did not set pending");
    ack_clear_a: assert property (
        ackAlarm && !alarm |=> !intPending)
        else $error("acknowledge did not clear pending");
endmodule : swi_slave_sva
bind swi_slave swi_slave_sva #(.INT_LOW_CYC(INT_LOW_CYC)) chk (
    .clk(clk), .rst(rst), .lineIn(lineIn), .lineOe_n(lineOe_n),
    .alarm(alarm), .ackAlarm(ackAlarm), .intPending(intPending)
);
`default_nettype wire

/* File: dv/swi_master_model.sv */
// Bus master with pull-up facing the single-wire slave
`default_nettype none
module swi_master_model (
    // Clock
    input wire logic clk,
    // Wire
    input wire logic devOe_n,
    output logic lineLevel
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pullLow = 1'b0;
    // Pull-up: high unless some party pulls
    assign lineLevel = !(pullLow || !devOe_n);
    task automatic waitCyc(input int n);
        repeat (n) @(negedge clk);
    endtask : waitCyc
    // Reset pulse; returns the total low time seen on the wire
    task automatic busReset(output int lowCyc);
        int k;
        pullLow = 1'b1;
        waitCyc(10000);
        pullLow = 1'b0;
        lowCyc = 10000;
        for (k = 0; k < 100000 && !lineLevel; k++) begin
            @(negedge clk);
            lowCyc++;
        end
        waitCyc(9600);
    endtask : busReset
    // Read slot: short low, then sample at 1 us and 14.5 us
    task automatic readBit(output logic early, output logic late);
        pullLow = 1'b1;
        waitCyc(10);
        pullLow = 1'b0;
        waitCyc(10);
        early = lineLevel;
        waitCyc(270);
        late = lineLevel;
        waitCyc(1010);
    endtask : readBit
endmodule : swi_master_model
`default_nettype wire

/* File: dv/swi_slave_tb.sv */
// Self-checking bench for the single-wire slave
`default_nettype none
module swi_slave_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int INT_CYC = 20000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic lineLevel;
    logic lineOe_n;
    logic alarm = 1'b0;
    logic ackAlarm = 1'b0;
    logic addrOther = 1'b0;
    logic intPending;
    logic txValid = 1'b0;
    logic txReady;
    logic [7:0] txData = 8'h00;
    int failCount = 0;
    int nTests = 0;
    swi_master_model master (
        .clk(clk), .devOe_n(lineOe_n), .lineLevel(lineLevel));
    swi_slave #(.LATE_REVISION(1'b1), .INT_LOW_CYC(INT_CYC)) dut (
        .clk(clk), .rst(rst), .lineIn(lineLevel), .lineOut(),
        .lineOe_n(lineOe_n), .alarm(alarm), .ackAlarm(ackAlarm),
        .addressedSelf(1'b0), .addressedOther(addrOther),
        .intPending(intPending), .txValid(txValid), .txReady(txReady),
        .txData(txData), .rxValid(), .rxData());
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic check(input string what, input logic [16:0] seen,
                         input logic [16:0] exp);
        nTests++;
        if (seen !== exp) begin
            failCount++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    task automatic measure(input logic lvl, output int n);
        n = 0;
        while (lineOe_n === lvl && n < 100000) begin
            @(negedge clk);
            n++;
        end
    endtask : measure
    task automatic pulseAlarm();
        alarm = 1'b1;
        @(negedge clk);
        alarm = 1'b0;
        @(negedge clk);
    endtask : pulseAlarm
    task automatic powerOn();
        int w;
        int p;
        measure(1'b1, w);
        measure(1'b0, p);
        check("presence wait", w inside {[300:1200]}, 1'b1);
        check("presence low", p inside {[1200:4800]}, 1'b1);
    endtask : powerOn
    task automatic readFifo();
        int n;
        logic early;
        logic late;
        logic [7:0] exp;
        n = 0;
        exp = 8'hA5;
        while (txReady === 1'b1 && n < 12) begin
            txData = (n == 0) ? exp : 8'h3C;
            txValid = 1'b1;
            @(negedge clk);
            n++;
        end
        txValid = 1'b0;
        check("fifo depth", n, 8);
        for (int i = 0; i < 8; i++) begin
            master.readBit(early, late);
            check("read bit early", early, exp[i]);
            check("read bit late", late, exp[i]);
        end
        check("fifo ready after pop", txReady, 1'b1);
        addrOther = 1'b1;
        @(negedge clk);
        addrOther = 1'b0;
    endtask : readFifo
    task automatic alarmInReset();
        int n;
        fork
            master.busReset(n);
            begin
                master.waitCyc(9700);
                pulseAlarm();
                check("pull on alarm", lineOe_n, 1'b0);
            end
        join
        check("long low", n inside {[19200:96000]}, 1'b1);
        check("pending set", intPending, 1'b1);
    endtask : alarmInReset
    task automatic repeatThenAck();
        int n;
        master.busReset(n);
        check("repeat stretch", n inside {[19200:76800]}, 1'b1);
        check("still pending", intPending, 1'b1);
        ackAlarm = 1'b1;
        @(negedge clk);
        ackAlarm = 1'b0;
        @(negedge clk);
        check("acknowledged", intPending, 1'b0);
        master.busReset(n);
        check("plain reset", n inside {[10000:10002]}, 1'b1);
    endtask : repeatThenAck
    task automatic spontaneous();
        int n;
        int w;
        int p;
        pulseAlarm();
        check("spontaneous pull", lineOe_n, 1'b0);
        measure(1'b0, n);
        check("spont length", n inside {[INT_CYC-3:INT_CYC]}, 1'b1);
        measure(1'b1, w);
        measure(1'b0, p);
        check("presence after", p inside {[1200:4800]}, 1'b1);
    endtask : spontaneous
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        powerOn();
        readFifo();
        alarmInReset();
        repeatThenAck();
        spontaneous();
        summarize();
    end
    // Watchdog sized from the expected run of about 114000 cycles
    initial begin
        repeat (125000) @(posedge clk);
        failCount++;
        summarize();
    end
endmodule : swi_slave_tb
`default_nettype wire
